// ==== bit_sync.sv ====
// Two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : bit_sync

// ==== dual_rail_fault_supervisor.sv ====
// Top level of the dual rail fault supervisor
`timescale 1ns/1ps
module dual_rail_fault_supervisor #(
  parameter int UV_CYCLES = supervisor_pkg::UV_FILTER_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic enable_in,
  input wire logic supply_low_in,
  input wire logic vcc_uvlo_ok_in,
  input wire logic junction_hot_in,
  input wire logic junction_cool_in,
  input wire logic thermistor_in_a_in,
  input wire logic thermistor_in_b_in,
  input wire logic sense_a_phase3_in,
  input wire logic sense_a_phase2_in,
  input wire logic sense_b_phase2_in,
  input wire logic [1:0] soft_start_done_in,
  input wire logic [1:0] fb_in_window_in,
  input wire logic [1:0] fb_under_in,
  input wire logic [1:0] fb_over_in,
  input wire logic [1:0] fb_over_fixed_in,
  input wire logic [1:0] vr_settled_in,
  input wire logic [1:0] current_limit_in,
  input wire logic [2:0] high_side_off_in,
  input wire logic [2:0] low_side_off_in,
  input wire logic [2:0] zero_cross_in,
  input wire logic [4:0] phase_pwm_in,
  input wire logic [1:0] power_state_a_in,
  input wire logic [1:0] power_state_b_in,
  input wire logic acq_valid_in,
  input wire logic [supervisor_pkg::CURRENT_W-1:0] acq_current_a_in,
  input wire logic [supervisor_pkg::CURRENT_W-1:0] acq_current_b_in,
  input wire logic [supervisor_pkg::ZONE_W-1:0] acq_zone_a_in,
  input wire logic [supervisor_pkg::ZONE_W-1:0] acq_zone_b_in,
  input wire logic reg_rail_sel_in,
  input wire logic [7:0] reg_addr_in,
  output logic power_good_rail_a_out,
  output logic power_good_rail_a_oe_out,
  output logic power_good_rail_b_out,
  output logic power_good_rail_b_oe_out,
  output logic thermal_alert_n_out,
  output logic [2:0] high_side_gate_out,
  output logic [2:0] low_side_gate_out,
  output logic [1:0] ext_driver_pwm_out,
  output logic [1:0] ext_driver_pwm_oe_out,
  output logic [1:0] discharge_out,
  output logic fault_latched_out,
  output logic [7:0] reg_rdata_out
);
  import supervisor_pkg::*;

  localparam int SYNC_W = 33;

  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_q;
  logic en_s, sup_low_s, vcc_ok_s, jhot_s, jcool_s;
  logic tha_s, thb_s, a3_tie_s, a2_tie_s, b2_tie_s;
  logic [1:0] ss_s, win_s, under_s, over_s, ovfix_s, settled_s, climit_s;
  logic [2:0] hs_off_s, ls_off_s, zc_s;

  logic [1:0] skip, track_q, fixed_mode, ov_fault, uv_trip, pg_rel;
  logic ov_any, uv_any, therm_fault, uvlo_fault, fault_set, drive_ok;
  logic fault_q, ov_latch_q, thermal_hold_q, por_seen_q, run_q;
  logic [1:0] uv_latch_q;
  logic [2:0] phase_off_q;
  logic [2:0] gate_act, gate_skip;
  logic [1:0] ext_act;
  logic [2:0] hs_q, ls_q;
  logic [1:0] ext_q, ext_oe_q, dis_q, pg_oe_q;
  logic pg_level_q, alert_n_q;
  logic [CURRENT_W-1:0] current_q [NUM_RAILS];
  logic [ZONE_W-1:0] zone_q [NUM_RAILS];
  logic [7:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator levels arrive asynchronously and are all synchronised here
  assign sync_raw = {enable_in, supply_low_in, vcc_uvlo_ok_in,
                     junction_hot_in, junction_cool_in,
                     thermistor_in_a_in, thermistor_in_b_in,
                     sense_a_phase3_in, sense_a_phase2_in, sense_b_phase2_in,
                     soft_start_done_in, fb_in_window_in, fb_under_in,
                     fb_over_in, fb_over_fixed_in, vr_settled_in,
                     current_limit_in, high_side_off_in, low_side_off_in,
                     zero_cross_in};

  bit_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .async_in(sync_raw),
    .sync_out(sync_q)
  );

  assign {en_s, sup_low_s, vcc_ok_s, jhot_s, jcool_s, tha_s, thb_s,
          a3_tie_s, a2_tie_s, b2_tie_s, ss_s, win_s, under_s, over_s,
          ovfix_s, settled_s, climit_s, hs_off_s, ls_off_s, zc_s} = sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // Soft-start always runs forced PWM, whatever power state is requested
  assign skip[0] = (power_state_a_in == PS_TWO ||
                    power_state_a_in == PS_THREE) && ss_s[0];
  assign skip[1] = (power_state_b_in == PS_TWO ||
                    power_state_b_in == PS_THREE) && ss_s[1];

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      track_q <= 2'h0;
    end else begin
      for (int r = 0; r < NUM_RAILS; r++) begin
        if (!skip[r]) begin
          track_q[r] <= 1'b0;
        end else if (settled_s[r]) begin
          track_q[r] <= 1'b1;
        end
      end
    end
  end

  assign fixed_mode = skip & ~track_q;
  assign ov_fault = en_s ? ((fixed_mode & ovfix_s) |
                            (~fixed_mode & over_s)) : 2'h0;
  assign ov_any = |ov_fault;
  assign uv_any = |uv_trip;
  assign therm_fault = jhot_s;
  assign uvlo_fault = por_seen_q && !vcc_ok_s;
  assign fault_set = ov_any || uv_any || therm_fault || uvlo_fault;
  assign drive_ok = run_q && !fault_q && !fault_set;

  ////////////////////////////////////////////////////////////////////////////
  // A new fault wins over a clear arriving in the same cycle
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fault_q <= 1'b0;
      ov_latch_q <= 1'b0;
      uv_latch_q <= 2'h0;
    end else if (fault_set) begin
      fault_q <= 1'b1;
      ov_latch_q <= ov_latch_q | ov_any;
      uv_latch_q <= uv_latch_q | uv_trip;
    end else if (!en_s || sup_low_s) begin
      fault_q <= 1'b0;
      ov_latch_q <= 1'b0;
      uv_latch_q <= 2'h0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      thermal_hold_q <= 1'b0;
    end else if (therm_fault) begin
      thermal_hold_q <= 1'b1;
    end else if (jcool_s) begin
      thermal_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      por_seen_q <= 1'b0;
    end else if (sup_low_s) begin
      por_seen_q <= 1'b0;
    end else if (vcc_ok_s) begin
      por_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_q <= 1'b0;
    end else begin
      run_q <= en_s && vcc_ok_s && !fault_q && !fault_set &&
               !thermal_hold_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Straps are only looked at while disabled, so they settle before startup
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_off_q <= 3'h0;
    end else if (!en_s) begin
      phase_off_q <= {b2_tie_s, a2_tie_s, a3_tie_s};
    end
  end

  // Gate 0 and 1 belong to rail A, gate 2 to rail B
  assign gate_act = {1'b1, ~phase_off_q[1] & ~skip[0], 1'b1};
  assign gate_skip = {skip[1], skip[0], skip[0]};
  assign ext_act = {~phase_off_q[2] & ~skip[1],
                    ~phase_off_q[0] & ~phase_off_q[1] & ~skip[0]};

  ////////////////////////////////////////////////////////////////////////////
  rail_monitor #(
    .UV_CYCLES(UV_CYCLES)
  ) u_rail_a (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .run_in(run_q),
    .soft_start_done_in(ss_s[0]),
    .in_window_in(win_s[0]),
    .under_in(under_s[0]),
    .over_in(over_s[0]),
    .current_limit_in(climit_s[0]),
    .pg_release_out(pg_rel[0]),
    .uv_trip_out(uv_trip[0])
  );

  rail_monitor #(
    .UV_CYCLES(UV_CYCLES)
  ) u_rail_b (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .run_in(run_q),
    .soft_start_done_in(ss_s[1]),
    .in_window_in(win_s[1]),
    .under_in(under_s[1]),
    .over_in(over_s[1]),
    .current_limit_in(climit_s[1]),
    .pg_release_out(pg_rel[1]),
    .uv_trip_out(uv_trip[1])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Overvoltage skips the dead-time wait: discharging the output comes first
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hs_q <= 3'h0;
      ls_q <= 3'h0;
    end else begin
      for (int g = 0; g < NUM_GATES; g++) begin
        if (ov_any || ov_latch_q) begin
          hs_q[g] <= 1'b0;
          ls_q[g] <= 1'b1;
        end else if (!drive_ok || !gate_act[g]) begin
          hs_q[g] <= 1'b0;
          ls_q[g] <= 1'b0;
        end else if (phase_pwm_in[g]) begin
          hs_q[g] <= ls_off_s[g];
          ls_q[g] <= 1'b0;
        end else begin
          hs_q[g] <= 1'b0;
          ls_q[g] <= hs_off_s[g] && !(gate_skip[g] && zc_s[g]);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ext_q <= 2'h0;
      ext_oe_q <= 2'h0;
    end else begin
      for (int e = 0; e < NUM_EXT; e++) begin
        ext_oe_q[e] <= drive_ok && ext_act[e];
        ext_q[e] <= drive_ok && ext_act[e] && phase_pwm_in[NUM_GATES + e];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dis_q <= 2'h0;
    end else begin
      dis_q <= uv_latch_q | uv_trip | {2{!en_s}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-good is open drain: the pin level is always low, the enable pulls
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pg_oe_q <= 2'h3;
      pg_level_q <= 1'b0;
    end else begin
      pg_oe_q <= ~pg_rel;
      pg_level_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      alert_n_q <= 1'b1;
    end else begin
      alert_n_q <= !(tha_s || thb_s);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int r = 0; r < NUM_RAILS; r++) begin
        current_q[r] <= REG_RESET;
        zone_q[r] <= ZONE_W'(REG_RESET);
      end
    end else if (acq_valid_in) begin
      current_q[0] <= acq_current_a_in;
      current_q[1] <= acq_current_b_in;
      zone_q[0] <= acq_zone_a_in;
      zone_q[1] <= acq_zone_b_in;
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= REG_RESET;
    end else if (reg_addr_in == THERMAL_ZONE_ADDR) begin
      rdata_q <= {5'h00, zone_q[reg_rail_sel_in]};
    end else if (reg_addr_in == LOAD_CURRENT_ADDR) begin
      rdata_q <= current_q[reg_rail_sel_in];
    end else begin
      rdata_q <= REG_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign power_good_rail_a_out = pg_level_q;
  assign power_good_rail_b_out = pg_level_q;
  assign power_good_rail_a_oe_out = pg_oe_q[0];
  assign power_good_rail_b_oe_out = pg_oe_q[1];
  assign thermal_alert_n_out = alert_n_q;
  assign high_side_gate_out = hs_q;
  assign low_side_gate_out = ls_q;
  assign ext_driver_pwm_out = ext_q;
  assign ext_driver_pwm_oe_out = ext_oe_q;
  assign discharge_out = dis_q;
  assign fault_latched_out = fault_q;
  assign reg_rdata_out = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  a_ov_safe_state: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    ov_any |=> ls_q == 3'h7 && hs_q == 3'h0 && ext_oe_q == 2'h0)
    else $error("overvoltage did not force the safe gate state");

  a_ov_fixed_level: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    en_s && skip[0] && !track_q[0] && ovfix_s[0] |=> fault_q)
    else $error("fixed overvoltage level ignored in skip mode");

  a_fault_hold: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    fault_q && en_s && !sup_low_s |=> fault_q)
    else $error("fault latch cleared without enable or supply cycle");

  a_latch_all_off: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    fault_q |=> hs_q == 3'h0 && ext_oe_q == 2'h0 && !run_q)
    else $error("a phase kept switching with the fault latch set");

  a_uv_safe_state: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    uv_trip[0] && !ov_any && !ov_latch_q
    |=> ls_q == 3'h0 && hs_q == 3'h0 && dis_q[0] && fault_q)
    else $error("undervoltage did not shut down and discharge");

  a_therm_restart: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    thermal_hold_q && !jcool_s |=> !run_q [*2])
    else $error("restart before junction cooled");

  a_dead_time: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    (hs_q & ~$past(ls_off_s)) == 3'h0)
    else $error("high side driven before low side sensed off");

  a_thermal_alert: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    tha_s || thb_s |=> !thermal_alert_n_out)
    else $error("thermal alert not asserted");

  a_phase_disable: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    phase_off_q[0] || phase_off_q[1] |=> !ext_driver_pwm_oe_out[0])
    else $error("disabled phase driven on external driver");

  a_uvlo_fault: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    por_seen_q && !vcc_ok_s |=> fault_q && hs_q == 3'h0)
    else $error("bias undervoltage did not latch the fault");

  a_zone_width: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    reg_addr_in == THERMAL_ZONE_ADDR |=> reg_rdata_out[7:3] == 5'h00)
    else $error("thermal zone register has bits above the zone");
endmodule : dual_rail_fault_supervisor

// ==== power_stage.sv ====
// Power stage model reporting gate off sense back to the supervisor
`timescale 1ns/1ps
module power_stage (
  input wire logic sys_clk_in,
  input wire logic [2:0] high_side_gate_in,
  input wire logic [2:0] low_side_gate_in,
  output logic [2:0] high_side_off_out,
  output logic [2:0] low_side_off_out
);
  initial begin
    high_side_off_out = 3'h7;
    low_side_off_out = 3'h7;
  end
  // Gate charge lingers a cycle, so off is seen late, never early
  always @(posedge sys_clk_in) begin
    high_side_off_out <= ~high_side_gate_in;
    low_side_off_out <= ~low_side_gate_in;
  end
endmodule : power_stage

// ==== rail_monitor.sv ====
// Per rail power-good window with blanking and undervoltage filter
`timescale 1ns/1ps
module rail_monitor #(
  parameter int UV_CYCLES = supervisor_pkg::UV_FILTER_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic run_in,
  input wire logic soft_start_done_in,
  input wire logic in_window_in,
  input wire logic under_in,
  input wire logic over_in,
  input wire logic current_limit_in,
  output logic pg_release_out,
  output logic uv_trip_out
);
  import supervisor_pkg::*;
  localparam int BLANK_W = $clog2(PG_BLANK_CYCLES + 1);
  localparam int UV_W = $clog2(UV_CYCLES + 1);
  localparam logic [BLANK_W-1:0] BLANK_LAST = BLANK_W'(PG_BLANK_CYCLES - 1);
  localparam logic [UV_W-1:0] UV_LAST = UV_W'(UV_CYCLES - 1);

  pg_state_e state_q;
  logic [BLANK_W-1:0] blank_cnt_q;
  logic [UV_W-1:0] uv_cnt_q;
  logic pg_q, uv_q, active, over_guard, keep;

  assign active = run_in && soft_start_done_in;
  // Current limit drags the output down, so the upper bound is ignored
  assign over_guard = over_in && !current_limit_in;
  assign keep = !under_in && !over_guard;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= PG_OFF;
      blank_cnt_q <= '0;
    end else if (!active) begin
      state_q <= PG_OFF;
      blank_cnt_q <= '0;
    end else begin
      case (state_q)
        PG_OFF: begin
          state_q <= PG_BLANK;
          blank_cnt_q <= '0;
        end
        PG_BLANK: begin
          if (blank_cnt_q == BLANK_LAST) begin
            state_q <= PG_WATCH;
          end else begin
            blank_cnt_q <= blank_cnt_q + 1'b1;
          end
        end
        PG_WATCH: state_q <= PG_WATCH;
        default: state_q <= PG_OFF;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pg_q <= 1'b0;
    end else if (!active || state_q != PG_WATCH) begin
      pg_q <= 1'b0;
    end else if (pg_q) begin
      pg_q <= keep;
    end else begin
      pg_q <= in_window_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A dip shorter than the filter restarts the count from zero
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      uv_cnt_q <= '0;
      uv_q <= 1'b0;
    end else if (!active || !under_in) begin
      uv_cnt_q <= '0;
      uv_q <= 1'b0;
    end else begin
      if (uv_cnt_q != UV_LAST) begin
        uv_cnt_q <= uv_cnt_q + 1'b1;
      end
      uv_q <= (uv_cnt_q == UV_LAST);
    end
  end

  assign pg_release_out = pg_q;
  assign uv_trip_out = uv_q;

  ////////////////////////////////////////////////////////////////////////////
  a_pg_off_low: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    !active |=> !pg_q)
    else $error("power-good released while off or in soft-start");

  a_pg_window_release: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    $rose(pg_q) |-> $past(in_window_in) && $past(state_q == PG_WATCH))
    else $error("power-good released outside window or blanking");

  a_pg_under_drop: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    pg_q && under_in |=> !pg_q)
    else $error("power-good kept during undervoltage");

  a_pg_current_limit: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    pg_q && active && state_q == PG_WATCH && !under_in && current_limit_in
    |=> pg_q)
    else $error("power-good dropped in current limit above undervoltage");

  a_uv_short_dip: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    !under_in |=> !uv_q && uv_cnt_q == '0)
    else $error("undervoltage filter not reset by recovery");

  a_uv_full_count: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    $rose(uv_q) |-> $past(uv_cnt_q) == UV_LAST && $past(under_in))
    else $error("undervoltage declared before filter time");
endmodule : rail_monitor

// ==== supervisor_pkg.sv ====
// Constants and types shared by the dual rail fault supervisor
// Overview of operation
// - Each rail has its own power-good output from its own comparators.
// - Power-good is held low in shutdown, during soft-start and shutdown.
// - Power-good releases about 20us after soft-start if feedback is inside the window.
// - Power-good drops when feedback is 200mV off target or the controller stops.
// - In current limit power-good stays released until undervoltage is reached.
// - Thermal alert goes low when either thermistor comparator reports overtemperature.
// - Overvoltage trips above target plus 200mV, or above 1.77V in skip.
// - In skip states the fixed 1.77V level applies until output is settled.
// - Overvoltage forces low side on, high side off, external PWM tri-state.
// - The fault latch clears only on enable toggle or supply below 0.5V.
// - Undervoltage trips only after 200mV undershoot persists for about 200us.
// - Undervoltage enables discharge, latches fault, turns gates off, tri-states PWM.
// - Junction overtemperature latches fault, turns gates off, tri-states PWM.
// - After thermal fault restart waits until the junction has cooled by 15C.
// - Adaptive dead time: outside overvoltage, no gate turns on until the other is sensed off.
// - Sense inputs tied to supply at startup disable the matching phases.
// - External driver PWM outputs trigger the extra phase of each rail.
// - Acquired current is an 8-bit register, thermistor zone a 3-bit value.
// - Two register files of identical layout, one for each rail.
// - Power states two and three are skip mode; zero and one forced PWM.
// - Bias supply below 4.25V after power-on latches fault and stops both rails.
package supervisor_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PG_BLANK_NS = 20000;
  localparam int PG_BLANK_CYCLES = (PG_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UV_FILTER_NS = 200000;
  localparam int UV_FILTER_CYCLES = UV_FILTER_NS / CLK_PERIOD_NS;
  localparam logic [7:0] THERMAL_ZONE_ADDR = 8'h12;
  localparam logic [7:0] LOAD_CURRENT_ADDR = 8'h21;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int ZONE_W = 3;
  localparam int CURRENT_W = 8;
  localparam int NUM_RAILS = 2;
  localparam int NUM_GATES = 3;
  localparam int NUM_EXT = 2;
  localparam logic [1:0] PS_TWO = 2'h2;
  localparam logic [1:0] PS_THREE = 2'h3;
  typedef enum logic [1:0] {PG_OFF, PG_BLANK, PG_WATCH} pg_state_e;
endpackage : supervisor_pkg

// ==== tb.sv ====
// Self-checking bench for the dual rail fault supervisor
`timescale 1ns/1ps
`define chk(a, b) begin num_checks++; if ((a) !== (b)) begin \
  num_errors++; $display("Error %0t ns: mismatch", $time); end end
module tb;
  import supervisor_pkg::*;
  logic sys_clk_in = 1'b0, arst_n_in = 1'b0, en = 1'b0, therm = 1'b0;
  logic jhot = 1'b0, acq = 1'b0, sel = 1'b0;
  logic sup_low = 1'b0, vcc_ok = 1'b1, jcool = 1'b1, tha = 1'b0, a2 = 1'b0;
  logic [1:0] climit = 2'h0, psa = 2'h0, psb = 2'h0;
  logic [1:0] ovfix = 2'h0, settled = 2'h0;
  logic [4:0] pwm = 5'h00;
  logic [1:0] ss = 2'h0, win = 2'h0, under = 2'h0, over = 2'h0;
  logic [7:0] cur = 8'h00, addr = 8'h00, rdata;
  logic [2:0] zone = 3'h0, hs, ls, hs_off, ls_off;
  logic [1:0] ext_oe, dis, ext;
  logic pa_oe, pb_oe, alert_n, fault, pa, pb;
  int num_errors = 0, num_checks = 0, cycles = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  dual_rail_fault_supervisor #(.UV_CYCLES(16)) uut (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .enable_in(en),
    .supply_low_in(sup_low), .vcc_uvlo_ok_in(vcc_ok),
    .junction_hot_in(jhot), .junction_cool_in(jcool),
    .thermistor_in_a_in(tha), .thermistor_in_b_in(therm),
    .sense_a_phase3_in(1'b0), .sense_a_phase2_in(a2),
    .sense_b_phase2_in(1'b0),
    .soft_start_done_in(ss), .fb_in_window_in(win), .fb_under_in(under),
    .fb_over_in(over), .fb_over_fixed_in(ovfix), .vr_settled_in(settled),
    .current_limit_in(climit), .high_side_off_in(hs_off),
    .low_side_off_in(ls_off), .zero_cross_in(3'h0), .phase_pwm_in(pwm),
    .power_state_a_in(psa), .power_state_b_in(psb), .acq_valid_in(acq),
    .acq_current_a_in(cur), .acq_current_b_in(8'h00),
    .acq_zone_a_in(3'h0), .acq_zone_b_in(zone), .reg_rail_sel_in(sel),
    .reg_addr_in(addr), .power_good_rail_a_out(pa),
    .power_good_rail_a_oe_out(pa_oe), .power_good_rail_b_out(pb),
    .power_good_rail_b_oe_out(pb_oe), .thermal_alert_n_out(alert_n),
    .high_side_gate_out(hs), .low_side_gate_out(ls),
    .ext_driver_pwm_out(ext), .ext_driver_pwm_oe_out(ext_oe),
    .discharge_out(dis), .fault_latched_out(fault), .reg_rdata_out(rdata));
  power_stage stage (.sys_clk_in(sys_clk_in), .high_side_gate_in(hs),
    .low_side_gate_in(ls), .high_side_off_out(hs_off),
    .low_side_off_out(ls_off));
  task automatic w(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : w
  task automatic rd(input logic [7:0] a, input logic s, input logic [7:0] e);
    addr = a;
    sel = s;
    w(2);
    `chk(rdata, e)
  endtask : rd
  task automatic t_regs;
    cur = 8'ha5;
    zone = 3'h5;
    acq = 1'b1;
    w(1);
    acq = 1'b0;
    rd(THERMAL_ZONE_ADDR, 1'b1, 8'h05);
    rd(LOAD_CURRENT_ADDR, 1'b0, 8'ha5);
    rd(8'h33, 1'b0, 8'h00);
  endtask : t_regs
  task automatic t_ov;
    en = 1'b1;
    w(5);
    over = 2'h1;
    w(6);
    `chk({fault, ls, hs, ext_oe}, 9'h1e0)
    over = 2'h0;
    en = 1'b0;
    w(6);
    `chk({fault, pa_oe, pb_oe}, 3'h3)
  endtask : t_ov
  task automatic t_uv;
    en = 1'b1;
    ss = 2'h3;
    win = 2'h3;
    w(2015);
    `chk({pa_oe, pb_oe}, 2'h0)
    `chk({pa, pb}, 2'h0)
    win = 2'h0;
    climit = 2'h1;
    under = 2'h2;
    w(10);
    under = 2'h0;
    w(4);
    `chk({fault, pa_oe, pb_oe}, 3'h1)
    `chk(pa_oe, 1'b0)
    under = 2'h2;
    w(30);
    `chk({fault, dis[1], hs, ls, ext_oe}, 10'h300)
    under = 2'h0;
    climit = 2'h0;
    en = 1'b0;
    ss = 2'h0;
    w(6);
  endtask : t_uv
  task automatic t_hot;
    therm = 1'b1;
    w(5);
    `chk(alert_n, 1'b0)
    therm = 1'b0;
    en = 1'b1;
    w(5);
    `chk(alert_n, 1'b1)
    tha = 1'b1;
    w(5);
    `chk(alert_n, 1'b0)
    tha = 1'b0;
    jhot = 1'b1;
    w(6);
    `chk({fault, hs, ls, ext_oe}, 9'h100)
    jhot = 1'b0;
    jcool = 1'b0;
    en = 1'b0;
    w(6);
    en = 1'b1;
    w(6);
    `chk({fault, ls}, 4'h0)
    jcool = 1'b1;
    w(6);
    `chk({fault, ls}, 4'h7)
  endtask : t_hot
  task automatic t_drv;
    pwm = 5'h1f;
    w(6);
    `chk({hs, ls}, 6'h38)
    `chk({ext, ext_oe}, 4'hf)
  endtask : t_drv
  // Rail B stays forced PWM because its soft-start is not done
  task automatic t_skip;
    psa = 2'h2;
    psb = 2'h3;
    ss = 2'h1;
    settled = 2'h1;
    w(5);
    `chk({hs, ext_oe}, 5'h16)
    ovfix = 2'h1;
    w(5);
    `chk(fault, 1'b0)
    psa = 2'h0;
    settled = 2'h0;
    w(2);
    psa = 2'h2;
    w(5);
    `chk({fault, ls, hs}, 7'h78)
    ovfix = 2'h0;
    psa = 2'h0;
    psb = 2'h0;
    ss = 2'h0;
    a2 = 1'b1;
    en = 1'b0;
    w(6);
    en = 1'b1;
    w(8);
    `chk({fault, hs, ext_oe}, 6'h16)
    a2 = 1'b0;
  endtask : t_skip
  task automatic t_uvlo;
    vcc_ok = 1'b0;
    w(5);
    `chk({fault, hs}, 4'h8)
    vcc_ok = 1'b1;
    w(5);
    `chk(fault, 1'b1)
    sup_low = 1'b1;
    w(5);
    `chk(fault, 1'b0)
    sup_low = 1'b0;
  endtask : t_uvlo
  task automatic close_out;
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  // Bound the run so a stuck wait cannot hang the simulator
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    w(3);
    arst_n_in = 1'b1;
    t_regs();
    t_ov();
    t_uv();
    t_hot();
    t_drv();
    t_skip();
    t_uvlo();
    close_out();
  end
endmodule : tb
